// *** design/gpwk_pkg.sv ***
/*
 * Constants, field layouts and carrier types for the six-port GPIO block.
 * Assumes a byte-wide data-memory access port and synchronous pin inputs.
 */
package gpwk_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_PORTS = 6;
	localparam int PORT_W = 8;
	localparam int ADDR_W = 8;
	localparam int PORT_A = 0;
	localparam int PORT_D = 3;
	localparam int PORT_E = 4;
	localparam int STRENGTH_BIT = 0;

	// ----------------------------------------------------------------
	// Data-memory map
	// ----------------------------------------------------------------
	localparam logic [7:0] PORT_STRIDE = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_DIR = 8'h01;
	localparam logic [7:0] OFS_PULLUP = 8'h02;
	localparam logic [7:0] OFS_FUNC = 8'h03;
	localparam logic [7:0] ADDR_WAKE = 8'h18;
	localparam logic [7:0] ADDR_STRENGTH = 8'h19;

	// ----------------------------------------------------------------
	// Reset values and implemented-bit masks
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [7:0] RST_DIR = 8'hff;
	localparam logic [7:0] RST_PULLUP = 8'h00;
	localparam logic [7:0] RST_WAKE = 8'h00;
	localparam logic [7:0] RST_FUNC = 8'h00;
	localparam logic RST_STRENGTH = 1'b0;
	localparam logic [7:0] STRENGTH_MASK = 8'h01;
	localparam logic [7:0] READ_NONE = 8'h00;
	localparam logic [NUM_PORTS*8-1:0] PORT_MASK = {
		8'hff, 8'h1f, 8'h7f, 8'hff, 8'hff, 8'hff};

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} gpwk_mem_req_type;

	typedef struct packed {
		logic ext_reset;
		logic wdt_timeout;
		logic core_idle;
	} gpwk_sys_ctl_type;

endpackage : gpwk_pkg

// *** design/gpwk_ports.sv ***
/*
 * Six-port GPIO block with pull-high control and port A wake-up.
 * Assumes pin inputs are synchronous to mclk and that the core issues
 * one-cycle read and write strobes on its data-memory access port.
 */
`timescale 1ns/100ps

module gpwk_ports #(
	parameter int PORT_COUNT = gpwk_pkg::NUM_PORTS
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire gpwk_pkg::gpwk_mem_req_type mem_req,
	output logic [7:0] mem_rdata,
	output logic mem_rvalid,
	input wire gpwk_pkg::gpwk_sys_ctl_type sys_ctl,
	input wire logic [PORT_COUNT*8-1:0] pin_in,
	input wire logic [PORT_COUNT*8-1:0] nmos_select,
	output logic [PORT_COUNT*8-1:0] pin_out,
	output logic [PORT_COUNT*8-1:0] pin_oe_n,
	output logic [PORT_COUNT*8-1:0] pullup_on,
	output logic [PORT_COUNT*8-1:0] pullup_strong,
	output logic wake_req
);

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (PORT_COUNT < 1 || PORT_COUNT > gpwk_pkg::NUM_PORTS) begin : g_chk
		$error("PORT_COUNT must lie between 1 and 6.");
	end

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [7:0] data_latch [PORT_COUNT];
	logic [7:0] dir [PORT_COUNT];
	logic [7:0] pullup_en [PORT_COUNT];
	logic [7:0] func_sel [PORT_COUNT];
	logic [7:0] wake_en;
	logic strength;
	logic [7:0] pin_prev;
	logic func_clear;
	logic [7:0] next_rdata;
	logic [PORT_COUNT*8-1:0] next_pullup_on;
	logic [PORT_COUNT*8-1:0] next_pin_out;
	logic [PORT_COUNT*8-1:0] next_oe_n;
	logic [7:0] wake_fall;
	logic [7:0] wake_ok;

	// Function selects survive a watchdog time-out taken while idle.
	assign func_clear = sys_ctl.ext_reset |
		(sys_ctl.wdt_timeout & ~sys_ctl.core_idle);

	for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
		localparam logic [7:0] BASE = 8'(p) * gpwk_pkg::PORT_STRIDE;
		localparam logic [7:0] MASK = gpwk_pkg::PORT_MASK[p*8 +: 8];
		logic wr_data;
		logic wr_dir;
		logic wr_pu;
		logic wr_func;

		assign wr_data = mem_req.wr &&
			mem_req.addr == BASE + gpwk_pkg::OFS_DATA;
		assign wr_dir = mem_req.wr &&
			mem_req.addr == BASE + gpwk_pkg::OFS_DIR;
		assign wr_pu = mem_req.wr &&
			mem_req.addr == BASE + gpwk_pkg::OFS_PULLUP;
		assign wr_func = mem_req.wr &&
			mem_req.addr == BASE + gpwk_pkg::OFS_FUNC;

		always_ff @(posedge mclk or posedge sys_rst) begin
			if (sys_rst) begin
				data_latch[p] <= gpwk_pkg::RST_DATA & MASK;
			end else if (wr_data) begin
				data_latch[p] <= mem_req.wdata & MASK;
			end
		end

		always_ff @(posedge mclk or posedge sys_rst) begin
			if (sys_rst) begin
				dir[p] <= gpwk_pkg::RST_DIR & MASK;
			end else if (wr_dir) begin
				dir[p] <= mem_req.wdata & MASK;
			end
		end

		always_ff @(posedge mclk or posedge sys_rst) begin
			if (sys_rst) begin
				pullup_en[p] <= gpwk_pkg::RST_PULLUP;
			end else if (wr_pu) begin
				pullup_en[p] <= mem_req.wdata & MASK;
			end
		end

		always_ff @(posedge mclk or posedge sys_rst) begin
			if (sys_rst) begin
				func_sel[p] <= gpwk_pkg::RST_FUNC;
			end else if (func_clear) begin
				func_sel[p] <= gpwk_pkg::RST_FUNC;
			end else if (wr_func) begin
				func_sel[p] <= mem_req.wdata & MASK;
			end
		end

		// Pull-high only for a GPIO input or an NMOS output function.
		assign next_pullup_on[p*8 +: 8] = pullup_en[p] & MASK &
			((~func_sel[p] & dir[p]) | nmos_select[p*8 +: 8]);
		assign next_pin_out[p*8 +: 8] = data_latch[p];
		// A selected shared function owns the pin, so GPIO lets go.
		assign next_oe_n[p*8 +: 8] = dir[p] | func_sel[p] | ~MASK;

		// A driven pin must be an output and carry its own latch value.
		property p_drive_latch;
			@(posedge mclk) disable iff (sys_rst)
			##1 pin_oe_n[p*8 +: 8] != 8'hff |->
				(~pin_oe_n[p*8 +: 8] & $past(dir[p])) == 8'h00 &&
				((pin_out[p*8 +: 8] ^ $past(data_latch[p])) &
				~pin_oe_n[p*8 +: 8]) == 8'h00;
		endproperty
		a_drive_latch: assert property (p_drive_latch)
			else $error("Pin driven while input or not from its latch.");
	end

	// ----------------------------------------------------------------
	// Global strength bit and port A wake enables
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			strength <= gpwk_pkg::RST_STRENGTH;
		end else if (mem_req.wr && mem_req.addr == gpwk_pkg::ADDR_STRENGTH) begin
			strength <= mem_req.wdata[gpwk_pkg::STRENGTH_BIT];
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wake_en <= gpwk_pkg::RST_WAKE;
		end else if (mem_req.wr && mem_req.addr == gpwk_pkg::ADDR_WAKE) begin
			wake_en <= mem_req.wdata;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = gpwk_pkg::READ_NONE;
		for (int p = 0; p < PORT_COUNT; p++) begin
			if (mem_req.addr == 8'(p) * gpwk_pkg::PORT_STRIDE +
					gpwk_pkg::OFS_DATA) begin
				// Inputs are not latched; outputs read back the latch.
				next_rdata = ((pin_in[p*8 +: 8] & dir[p]) |
					(data_latch[p] & ~dir[p])) &
					gpwk_pkg::PORT_MASK[p*8 +: 8];
			end
			if (mem_req.addr == 8'(p) * gpwk_pkg::PORT_STRIDE +
					gpwk_pkg::OFS_DIR) begin
				next_rdata = dir[p];
			end
			if (mem_req.addr == 8'(p) * gpwk_pkg::PORT_STRIDE +
					gpwk_pkg::OFS_PULLUP) begin
				next_rdata = pullup_en[p];
			end
			if (mem_req.addr == 8'(p) * gpwk_pkg::PORT_STRIDE +
					gpwk_pkg::OFS_FUNC) begin
				next_rdata = func_sel[p];
			end
		end
		if (mem_req.addr == gpwk_pkg::ADDR_WAKE) begin
			next_rdata = wake_en;
		end
		if (mem_req.addr == gpwk_pkg::ADDR_STRENGTH) begin
			next_rdata = {7'h00, strength} & gpwk_pkg::STRENGTH_MASK;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			mem_rdata <= gpwk_pkg::READ_NONE;
			mem_rvalid <= 1'b0;
		end else begin
			mem_rvalid <= mem_req.rd;
			if (mem_req.rd) begin
				mem_rdata <= next_rdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin drive and pull-high outputs
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_out <= '0;
			pin_oe_n <= '1;
		end else begin
			pin_out <= next_pin_out;
			pin_oe_n <= next_oe_n;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pullup_on <= '0;
			pullup_strong <= '0;
		end else begin
			pullup_on <= next_pullup_on;
			// Strength matters only where the pull-high is connected.
			pullup_strong <= next_pullup_on & {(PORT_COUNT*8){strength}};
		end
	end

	// ----------------------------------------------------------------
	// Port A wake-up
	// ----------------------------------------------------------------
	assign wake_fall = pin_prev & ~pin_in[gpwk_pkg::PORT_A*8 +: 8];
	assign wake_ok = wake_en & ~func_sel[gpwk_pkg::PORT_A] &
		dir[gpwk_pkg::PORT_A];

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_prev <= '0;
			wake_req <= 1'b0;
		end else begin
			pin_prev <= pin_in[gpwk_pkg::PORT_A*8 +: 8];
			wake_req <= sys_ctl.core_idle && |(wake_fall & wake_ok);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_read_a_inputs;
		mem_req.rd && mem_req.addr == gpwk_pkg::OFS_DATA &&
			dir[0] == 8'hff;
	endsequence

	property p_read_live;
		@(posedge mclk) disable iff (sys_rst)
		s_read_a_inputs |=> mem_rvalid && mem_rdata == $past(pin_in[7:0]);
	endproperty
	a_read_live: assert property (p_read_live)
		else $error("Port read did not return the live pin levels.");

	property p_latch_hold;
		@(posedge mclk) disable iff (sys_rst)
		!(mem_req.wr && mem_req.addr == gpwk_pkg::OFS_DATA) |=>
			$stable(data_latch[0]);
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("Output latch changed without a write.");

	property p_port_d_width;
		@(posedge mclk) disable iff (sys_rst)
		mem_req.rd && mem_req.addr == 8'(gpwk_pkg::PORT_D) *
			gpwk_pkg::PORT_STRIDE |=> !mem_rdata[7];
	endproperty
	a_port_d_width: assert property (p_port_d_width)
		else $error("Unimplemented port D bit read as one.");

	property p_pullup_enable;
		@(posedge mclk) disable iff (sys_rst)
		pullup_en[0][0] && !func_sel[0][0] && dir[0][0] |=> pullup_on[0];
	endproperty
	a_pullup_enable: assert property (p_pullup_enable)
		else $error("Enabled pull-high on a GPIO input was not connected.");

	property p_pullup_gate;
		@(posedge mclk) disable iff (sys_rst)
		func_sel[0][0] && !nmos_select[0] |=> !pullup_on[0];
	endproperty
	a_pullup_gate: assert property (p_pullup_gate)
		else $error("Pull-high connected under a shared function.");

	property p_strength_select;
		@(posedge mclk) disable iff (sys_rst)
		##1 pullup_strong == (pullup_on & {(PORT_COUNT*8){$past(strength)}});
	endproperty
	a_strength_select: assert property (p_strength_select)
		else $error("Pull-high strength does not follow the global bit.");

	property p_strength_only_enabled;
		@(posedge mclk) disable iff (sys_rst)
		(pullup_strong & ~pullup_on) == '0;
	endproperty
	a_strength_only_enabled: assert property (p_strength_only_enabled)
		else $error("Strong pull-high shown on a disabled pin.");

	property p_strength_read;
		@(posedge mclk) disable iff (sys_rst)
		mem_req.rd && mem_req.addr == gpwk_pkg::ADDR_STRENGTH |=>
			mem_rdata[7:1] == 7'h00 && mem_rdata[0] == $past(strength);
	endproperty
	a_strength_read: assert property (p_strength_read)
		else $error("Strength register read back wrongly.");

	sequence s_wake_fall;
		sys_ctl.core_idle && wake_en[0] && !func_sel[0][0] && dir[0][0]
			&& pin_prev[0] && !pin_in[0];
	endsequence

	property p_wake_on_fall;
		@(posedge mclk) disable iff (sys_rst)
		s_wake_fall |=> wake_req;
	endproperty
	a_wake_on_fall: assert property (p_wake_on_fall)
		else $error("Falling edge on a wake pin did not wake the core.");

	property p_wake_disabled;
		@(posedge mclk) disable iff (sys_rst)
		wake_en == 8'h00 |=> !wake_req;
	endproperty
	a_wake_disabled: assert property (p_wake_disabled)
		else $error("Wake request with every wake enable cleared.");

	property p_wake_awake;
		@(posedge mclk) disable iff (sys_rst)
		!sys_ctl.core_idle |=> !wake_req;
	endproperty
	a_wake_awake: assert property (p_wake_awake)
		else $error("Wake request while the core was running.");

	property p_func_clear;
		@(posedge mclk) disable iff (sys_rst)
		sys_ctl.ext_reset |=> func_sel[0] == gpwk_pkg::RST_FUNC;
	endproperty
	a_func_clear: assert property (p_func_clear)
		else $error("Function select not cleared by external reset.");

	property p_func_keep_idle;
		@(posedge mclk) disable iff (sys_rst)
		sys_ctl.wdt_timeout && sys_ctl.core_idle && !sys_ctl.ext_reset &&
			!mem_req.wr |=> $stable(func_sel[0]);
	endproperty
	a_func_keep_idle: assert property (p_func_keep_idle)
		else $error("Idle watchdog time-out disturbed a function select.");

endmodule : gpwk_ports

// *** tb/gpwk_pins_model.sv ***
/*
 * Model of the external pins: resolves each line from the block's drive,
 * an outside driver commanded by the bench and the internal pull-high.
 * Assumes a single clock, mclk, and pins listed as port*8+bit.
 */
`timescale 1ns/100ps

module gpwk_pins_model #(
	parameter int W = 48
) (
	input wire logic mclk,
	input wire logic [W-1:0] pin_out,
	input wire logic [W-1:0] pin_oe_n,
	input wire logic [W-1:0] pullup_on,
	input wire logic [W-1:0] ext_en,
	input wire logic [W-1:0] ext_val,
	output logic [W-1:0] level
);
	// A floating line shows a pattern that flips every cycle.
	logic [W-1:0] float_pat = '0;

	always @(posedge mclk) begin
		float_pat <= ~float_pat;
	end

	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (!pin_oe_n[i]) level[i] = pin_out[i];
			else if (ext_en[i]) level[i] = ext_val[i];
			else if (pullup_on[i]) level[i] = 1'b1;
			else level[i] = float_pat[i];
		end
	end
endmodule : gpwk_pins_model

// *** tb/test_gpio_ports_pullup_wakeup.sv ***
/*
 * Self-checking bench for the six-port GPIO block.
 * Assumes the pin model above and the designer's byte map.
 */
`timescale 1ns/100ps

module test_gpio_ports_pullup_wakeup;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	gpwk_pkg::gpwk_mem_req_type mem_req = '0;
	gpwk_pkg::gpwk_sys_ctl_type sys_ctl = '0;
	logic [47:0] nmos_select = '0;
	logic [47:0] ext_en = '0;
	logic [47:0] ext_val = '0;
	logic [47:0] pin_in, pin_out, pin_oe_n, pullup_on, pullup_strong;
	logic [7:0] mem_rdata;
	logic mem_rvalid, wake_req;
	int miscompares = 0;
	int cmp_count = 0;
	int wake_cnt = 0;

	gpwk_ports dut (.mclk(mclk), .sys_rst(sys_rst), .mem_req(mem_req),
		.mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .sys_ctl(sys_ctl),
		.pin_in(pin_in), .nmos_select(nmos_select), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .pullup_on(pullup_on),
		.pullup_strong(pullup_strong), .wake_req(wake_req));

	gpwk_pins_model pins (.mclk(mclk), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .pullup_on(pullup_on), .ext_en(ext_en),
		.ext_val(ext_val), .level(pin_in));

	initial begin
		forever #2.5 mclk = ~mclk;
	end

	always @(negedge mclk) begin
		if (wake_req === 1'b1) wake_cnt++;
	end

	// ----------------------------------------------------------------
	// Access and check tasks
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc

	task automatic chk(input string n, input logic [47:0] e,
		input logic [47:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		mem_req = '{a, 1'b1, 1'b0, d};
		cyc(1);
		mem_req.wr = 1'b0;
		cyc(1);
	endtask : wr

	task automatic rdc(input string n, input logic [7:0] a,
		input logic [7:0] e);
		mem_req = '{a, 1'b0, 1'b1, 8'h00};
		cyc(1);
		chk("rvalid", 48'h1, {47'h0, mem_rvalid});
		chk(n, {40'h0, e}, {40'h0, mem_rdata});
		mem_req.rd = 1'b0;
		cyc(1);
	endtask : rdc

	task automatic done(input string n);
		$display("test %s finished", n);
	endtask : done

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : report_and_stop

	initial begin
		#20000;
		miscompares++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		cyc(4);
		sys_rst = 1'b0;
		cyc(1);
		chk("oe_n", '1, pin_oe_n);
		rdc("wake", 8'h18, 8'h00);
		rdc("strength", 8'h19, 8'h00);
		for (int p = 0; p < 6; p++) begin
			rdc("pullup", 8'(p * 4 + 2), 8'h00);
			wr(8'(p * 4 + 2), 8'hff);
			rdc("pu mask", 8'(p * 4 + 2), gpwk_pkg::PORT_MASK[p*8 +: 8]);
			chk("pu on", gpwk_pkg::PORT_MASK[p*8 +: 8], pullup_on[p*8 +: 8]);
			wr(8'(p * 4 + 2), 8'h00);
		end
		wr(8'h1a, 8'hff);
		rdc("unmapped", 8'h1a, 8'h00);
		done("reset_map");
		ext_en[31:8] = '1;
		ext_val[31:8] = 24'hff3c3c;
		wr(8'h04, 8'ha5);
		wr(8'h05, 8'h00);
		chk("out", 48'ha5, pin_out[15:8]);
		chk("oe", 48'h00, pin_oe_n[15:8]);
		rdc("latch", 8'h04, 8'ha5);
		wr(8'h05, 8'h0f);
		rdc("mixed", 8'h04, 8'hac);
		rdc("live", 8'h08, 8'h3c);
		ext_val[23:16] = 8'hc3;
		rdc("live2", 8'h08, 8'hc3);
		rdc("d live", 8'h0c, 8'h7f);
		done("latch_live");
		wr(8'h02, 8'hff);
		chk("pu", 48'hff, pullup_on[7:0]);
		rdc("pa live", 8'h00, 8'hff);
		chk("weak", 48'h00, pullup_strong[7:0]);
		wr(8'h19, 8'hff);
		rdc("strength", 8'h19, 8'h01);
		chk("strong", 48'hff, pullup_strong[7:0]);
		wr(8'h02, 8'h0f);
		chk("strong", 48'h0f, pullup_strong[7:0]);
		wr(8'h03, 8'h03);
		chk("pu func", 48'h0c, pullup_on[7:0]);
		nmos_select[1:0] = 2'b11;
		cyc(2);
		chk("pu nmos", 48'h0f, pullup_on[7:0]);
		wr(8'h01, 8'hfb);
		chk("pu out", 48'h0b, pullup_on[7:0]);
		nmos_select[1:0] = 2'b00;
		wr(8'h01, 8'hff);
		wr(8'h03, 8'h00);
		wr(8'h19, 8'h00);
		done("pullup");
		ext_en[0] = 1'b1;
		ext_val[0] = 1'b1;
		wr(8'h18, 8'h01);
		sys_ctl.core_idle = 1'b1;
		cyc(2);
		ext_val[0] = 1'b0;
		cyc(4);
		chk("wake", 48'h1, wake_cnt);
		ext_val[0] = 1'b1;
		wr(8'h18, 8'h00);
		ext_val[0] = 1'b0;
		cyc(4);
		chk("wake off", 48'h1, wake_cnt);
		ext_val[0] = 1'b1;
		wr(8'h18, 8'h01);
		sys_ctl.core_idle = 1'b0;
		cyc(2);
		ext_val[0] = 1'b0;
		cyc(4);
		chk("wake awake", 48'h1, wake_cnt);
		sys_ctl.core_idle = 1'b1;
		wr(8'h03, 8'h01);
		ext_val[0] = 1'b1;
		cyc(2);
		ext_val[0] = 1'b0;
		cyc(4);
		chk("wake func", 48'h1, wake_cnt);
		done("wake");
		wr(8'h07, 8'hff);
		sys_ctl.wdt_timeout = 1'b1;
		cyc(1);
		sys_ctl.wdt_timeout = 1'b0;
		rdc("func idle", 8'h07, 8'hff);
		sys_ctl.core_idle = 1'b0;
		sys_ctl.wdt_timeout = 1'b1;
		cyc(1);
		sys_ctl.wdt_timeout = 1'b0;
		rdc("func wdt", 8'h07, 8'h00);
		rdc("func a", 8'h03, 8'h00);
		wr(8'h07, 8'hff);
		wr(8'h03, 8'h01);
		sys_ctl.ext_reset = 1'b1;
		cyc(1);
		sys_ctl.ext_reset = 1'b0;
		rdc("func ext", 8'h07, 8'h00);
		rdc("func a ext", 8'h03, 8'h00);
		rdc("pu kept", 8'h02, 8'h0f);
		done("func_reset");
		sys_rst = 1'b1;
		cyc(1);
		chk("pu rst", 48'h0, pullup_on);
		chk("oe rst", '1, pin_oe_n);
		sys_rst = 1'b0;
		cyc(1);
		rdc("pu rst", 8'h02, 8'h00);
		done("second_reset");
		report_and_stop();
	end
endmodule : test_gpio_ports_pullup_wakeup
